// >>> common/sccx_pkg.sv
// Operation
// R1 - Special code only while select is high
// R2 - Host sends only defined special codes
// R3 - Special codes are 8-bit binary byte values
// R4 - C0.1 sends -K28.5, then idle sequence
// R5 - C1.1 sends -K28.5, then ready sequence
// R6 - Host holds fill codes multiples of four
// R7 - Receiver reports K28.5 as C5.0/C1.7/C2.7
// R8 - C2.1 K28.5 by RD, next LSB adjusted
// R9 - C0.7 violation follows running disparity
// R10 - C0.7 equals send-violation input high
// R11 - Receiver C0.7 only for unknown characters
// R12 - C1.7 forces -K28.5; rx wrong RD+
// R13 - C2.7 forces +K28.5; rx wrong RD-
// R14 - C4.7 sends disparity violation character
// R15 - Receiver C4.7 on table hit, RD mismatch
package sccx_pkg;
    // Special character codes as seen on the byte pins
    localparam logic [7:0] SC_IDLE = 8'h20;
    localparam logic [7:0] SC_RRDY = 8'h21;
    localparam logic [7:0] SC_EOF = 8'h22;
    localparam logic [7:0] SC_K285 = 8'h05;
    localparam logic [7:0] SC_CRV = 8'hE0;
    localparam logic [7:0] SC_NK285 = 8'hE1;
    localparam logic [7:0] SC_PK285 = 8'hE2;
    localparam logic [7:0] SC_RDV = 8'hE4;
    localparam logic [7:0] SC_K28_LAST = 8'h07;
    localparam logic [7:0] SC_K_LAST = 8'h0B;
    // Data bytes used by the fill sequences
    localparam logic [7:0] D21_4 = 8'h95;
    localparam logic [7:0] D21_5 = 8'hB5;
    localparam logic [7:0] D10_2 = 8'h4A;
    // K byte values for the encoder
    localparam logic [4:0] K28_LOW = 5'h1C;
    localparam logic [7:0] K23_7 = 8'hF7;
    localparam logic [7:0] K27_7 = 8'hFB;
    localparam logic [7:0] K29_7 = 8'hFD;
    localparam logic [7:0] K30_7 = 8'hFE;
    // Raw ten-bit patterns, bit 9 is line bit a
    localparam logic [9:0] RAW_NK285 = 10'h0FA;
    localparam logic [9:0] RAW_PK285 = 10'h305;
    localparam logic [9:0] RAW_CRV_N = 10'h278;
    localparam logic [9:0] RAW_CRV_P = 10'h187;
    localparam logic [9:0] RAW_RDV_N = 10'h375;
    localparam logic [9:0] RAW_RDV_P = 10'h08A;
    localparam logic [3:0] ONES_NEUTRAL = 4'h5;
    localparam logic RD_RESET = 1'b0;

    typedef enum logic [4:0] {
        SCCX_FS_NONE = 5'b00001,
        SCCX_FS_K = 5'b00010,
        SCCX_FS_1 = 5'b00100,
        SCCX_FS_2 = 5'b01000,
        SCCX_FS_3 = 5'b10000
    } sccx_fill_t;

    typedef struct packed {
        logic raw_en;
        logic k;
        logic [7:0] byte_val;
        logic [9:0] raw;
    } sccx_tx_sym_t;

    typedef struct packed {
        logic sc;
        logic [7:0] byte_val;
    } sccx_rx_byte_t;
endpackage : sccx_pkg

// >>> hw/sccx_codec.sv
`timescale 1ns/1ps
`default_nettype none
module sccx_codec (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic special_char_select,
    input wire logic send_violation_symbol,
    input wire logic tx_rd,
    output logic tx_sym_valid,
    output sccx_pkg::sccx_tx_sym_t tx_sym,
    input wire logic rx_valid,
    input wire logic [9:0] rx_char,
    input wire logic rx_tab_hit_neg,
    input wire logic rx_tab_hit_pos,
    input wire logic rx_tab_k,
    input wire logic [7:0] rx_tab_byte,
    output logic rx_out_valid,
    output sccx_pkg::sccx_rx_byte_t rx_out,
    output logic rx_rd
);

    ////////////////////////////////////////////////////////////////////////////
    // Transmit side
    // One byte in, one symbol out, no buffering
    sccx_pkg::sccx_fill_t fill_r;
    sccx_pkg::sccx_fill_t fill_nxt;
    logic fill_rrdy_r;
    logic eof_pend_r;
    sccx_pkg::sccx_tx_sym_t tx_sym_nxt;

    // Byte classification, special only with select high
    wire is_sc = tx_valid & special_char_select; // R1 R3

    // Fill codes share one sequencer
    wire is_idle = is_sc & (tx_byte == sccx_pkg::SC_IDLE);
    wire is_rrdy = is_sc & (tx_byte == sccx_pkg::SC_RRDY);
    wire is_fill = is_idle | is_rrdy;

    // Single-byte commands
    wire is_eof = is_sc & (tx_byte == sccx_pkg::SC_EOF);
    wire is_nk = is_sc & (tx_byte == sccx_pkg::SC_NK285);
    wire is_pk = is_sc & (tx_byte == sccx_pkg::SC_PK285);
    wire is_rdv = is_sc & (tx_byte == sccx_pkg::SC_RDV);

    // Plain K codes, two ranges with different mappings
    wire is_k28 = is_sc & (tx_byte <= sccx_pkg::SC_K28_LAST);
    wire is_kx = is_sc & (tx_byte > sccx_pkg::SC_K28_LAST) & (tx_byte <= sccx_pkg::SC_K_LAST);

    // Reserved codes fall back to a violation so garbage never looks legal
    wire is_rsv = is_sc & ~is_fill & ~is_eof & ~is_nk & ~is_pk & ~is_rdv & ~is_k28 & ~is_kx;

    // Violation input and C0.7 share one path so they cannot drift apart
    wire is_crv = tx_valid & (send_violation_symbol | (is_sc & (tx_byte == sccx_pkg::SC_CRV)) | is_rsv); // R10

    // A change of fill code restarts at the comma
    wire fill_cont = is_fill & (fill_r != sccx_pkg::SCCX_FS_NONE) & (fill_rrdy_r == is_rrdy);

    // Comma opens a sequence and every fourth byte of a held one
    wire fill_start = is_fill & ~fill_cont;
    wire send_comma = fill_start | (fill_cont & (fill_r == sccx_pkg::SCCX_FS_K));

    // Fill sequence stepping; new data truncates a sequence in progress
    always_comb begin
        fill_nxt = sccx_pkg::SCCX_FS_NONE; // R6
        // Comma always resets the step count
        if (send_comma) begin
            fill_nxt = sccx_pkg::SCCX_FS_1;
        end else if (fill_cont) begin
            case (fill_r)
                sccx_pkg::SCCX_FS_1: fill_nxt = sccx_pkg::SCCX_FS_2;
                sccx_pkg::SCCX_FS_2: fill_nxt = sccx_pkg::SCCX_FS_3;
                sccx_pkg::SCCX_FS_3: fill_nxt = sccx_pkg::SCCX_FS_K;
                // Stale state outside the loop goes idle
                default: fill_nxt = sccx_pkg::SCCX_FS_NONE;
            endcase
        end
    end

    // Second and third fill data bytes depend on idle or ready flavour
    wire [7:0] fill_tail = is_rrdy ? sccx_pkg::D10_2 : sccx_pkg::D21_5; // R4 R5
    wire [7:0] fill_data = (fill_r == sccx_pkg::SCCX_FS_1) ? sccx_pkg::D21_4 : fill_tail;

    // K byte for the plain special codes
    wire [7:0] kx_byte = (tx_byte[1:0] == 2'h0) ? sccx_pkg::K23_7 :
                         (tx_byte[1:0] == 2'h1) ? sccx_pkg::K27_7 :
                         (tx_byte[1:0] == 2'h2) ? sccx_pkg::K29_7 : sccx_pkg::K30_7;

    // K28.y keeps the low five bits and takes y from the code
    wire [7:0] k28_byte = {tx_byte[2:0], sccx_pkg::K28_LOW};

    // LSB after EOF uses the disparity at the start of this character
    wire [7:0] eof_fix = {tx_byte[7:1], ~tx_rd}; // R8

    // Symbol selection, violations first since they override the byte
    always_comb begin
        // Defaults give a plain data symbol
        tx_sym_nxt = '0;
        if (is_crv) begin
            tx_sym_nxt.raw_en = 1'b1; // R9 R10
            tx_sym_nxt.raw = tx_rd ? sccx_pkg::RAW_CRV_P : sccx_pkg::RAW_CRV_N; // R9
        end else if (is_rdv) begin
            tx_sym_nxt.raw_en = 1'b1;
            tx_sym_nxt.raw = tx_rd ? sccx_pkg::RAW_RDV_P : sccx_pkg::RAW_RDV_N; // R14
        end else if (send_comma | is_nk) begin
            tx_sym_nxt.raw_en = 1'b1;
            tx_sym_nxt.raw = sccx_pkg::RAW_NK285; // R4 R5 R12
        end else if (is_pk) begin
            tx_sym_nxt.raw_en = 1'b1;
            tx_sym_nxt.raw = sccx_pkg::RAW_PK285; // R13
        end else if (fill_cont) begin
            tx_sym_nxt.byte_val = fill_data; // R4 R5
        end else if (is_eof) begin
            tx_sym_nxt.k = 1'b1;
            tx_sym_nxt.byte_val = {sccx_pkg::SC_K285[2:0], sccx_pkg::K28_LOW}; // R8
        end else if (is_k28) begin
            tx_sym_nxt.k = 1'b1;
            tx_sym_nxt.byte_val = k28_byte;
        end else if (is_kx) begin
            tx_sym_nxt.k = 1'b1;
            tx_sym_nxt.byte_val = kx_byte;
            // Delimiter fix applies to plain data only
        end else if (eof_pend_r) begin
            tx_sym_nxt.byte_val = eof_fix; // R8
        end else begin
            tx_sym_nxt.byte_val = tx_byte;
        end
    end

    // Transmit state and symbol register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fill_r <= sccx_pkg::SCCX_FS_NONE;
            fill_rrdy_r <= 1'b0;
            eof_pend_r <= 1'b0;
            tx_sym_valid <= 1'b0;
            tx_sym <= '0;
        end else begin
            // Fill state and flavour move every clock
            fill_r <= fill_nxt;
            fill_rrdy_r <= is_rrdy;
            // Pending EOF waits for the next presented byte
            if (tx_valid) begin
                eof_pend_r <= is_eof; // R8
            end
            // Symbol follows the byte by exactly one clock
            tx_sym_valid <= tx_valid;
            tx_sym <= tx_sym_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive side
    // Data and other K codes are decoded by the external tables
    // Tracked disparity starts negative out of reset
    logic rd_r;
    sccx_pkg::sccx_rx_byte_t rx_nxt;

    // Disparity of the received character from its ones count
    logic [3:0] ones;
    always_comb begin
        ones = 4'h0;
        for (int i = 0; i < 10; i++) begin
            ones = ones + {3'h0, rx_char[i]};
        end
    end

    // More than five ones leaves a positive disparity
    wire char_pos = ones > sccx_pkg::ONES_NEUTRAL;
    wire char_neg = ones < sccx_pkg::ONES_NEUTRAL;
    // A neutral character keeps the tracked disparity
    wire rd_nxt = char_pos ? 1'b1 : (char_neg ? 1'b0 : rd_r);

    // Commas are caught here, the tables leave K28.5 out
    wire rx_nk = rx_char == sccx_pkg::RAW_NK285;
    wire rx_pk = rx_char == sccx_pkg::RAW_PK285;

    // Table hit in the column that matches the tracked disparity
    wire tab_hit = rx_tab_hit_neg | rx_tab_hit_pos;
    wire tab_rd_ok = rd_r ? rx_tab_hit_pos : rx_tab_hit_neg;

    // Report selection; fill codes are never produced here
    always_comb begin
        rx_nxt.sc = 1'b1;
        // Wrong-polarity commas take precedence over the plain comma
        if (rx_nk & rd_r) begin
            rx_nxt.byte_val = sccx_pkg::SC_NK285; // R12
        end else if (rx_pk & ~rd_r) begin
            rx_nxt.byte_val = sccx_pkg::SC_PK285; // R13
        end else if (rx_nk | rx_pk) begin
            rx_nxt.byte_val = sccx_pkg::SC_K285; // R7
        end else if (!tab_hit) begin
            rx_nxt.byte_val = sccx_pkg::SC_CRV; // R11
        end else if (!tab_rd_ok) begin
            rx_nxt.byte_val = sccx_pkg::SC_RDV; // R15
        end else begin
            rx_nxt.sc = rx_tab_k; // R7
            rx_nxt.byte_val = rx_tab_byte;
        end
    end

    // Receive state and output register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_r <= sccx_pkg::RD_RESET;
            rx_out_valid <= 1'b0;
            rx_out <= '0;
        end else begin
            rx_out_valid <= rx_valid;
            // Report and disparity hold across gaps
            if (rx_valid) begin
                rd_r <= rd_nxt;
                rx_out <= rx_nxt;
            end
        end
    end

    // Tracked disparity on a pin for error monitoring
    assign rx_rd = rd_r;

endmodule : sccx_codec
`default_nettype wire

// >>> dv/sccx_codec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sccx_codec_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic special_char_select,
    input wire logic send_violation_symbol,
    input wire logic tx_rd,
    input wire sccx_pkg::sccx_tx_sym_t tx_sym,
    input wire logic rx_valid,
    input wire logic [9:0] rx_char,
    input wire logic rx_tab_hit_neg,
    input wire logic rx_tab_hit_pos,
    input wire logic rx_out_valid,
    input wire sccx_pkg::sccx_rx_byte_t rx_out,
    input wire logic rx_rd
);
    // One byte clock, so one default for every check
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Special code with the violation input low
    wire logic cmd = tx_valid && special_char_select && !send_violation_symbol;
    wire logic no_hit = !rx_tab_hit_neg && !rx_tab_hit_pos;
    ////////////////////////////////////////////////////////////////////////////
    a_crv_raw: assert property (tx_valid && (send_violation_symbol || special_char_select &&
        tx_byte == sccx_pkg::SC_CRV) |=> tx_sym.raw_en && tx_sym.raw == ($past(tx_rd) ?
        sccx_pkg::RAW_CRV_P : sccx_pkg::RAW_CRV_N)) else $error("bad violation raw");
    a_rdv_raw: assert property (cmd && tx_byte == sccx_pkg::SC_RDV |=> tx_sym.raw_en &&
        tx_sym.raw == ($past(tx_rd) ? sccx_pkg::RAW_RDV_P : sccx_pkg::RAW_RDV_N)) else $error("bad rd violation");
    a_neg_comma: assert property (cmd && tx_byte == sccx_pkg::SC_NK285 |=>
        tx_sym.raw_en && tx_sym.raw == sccx_pkg::RAW_NK285) else $error("bad forced neg comma");
    a_pos_comma: assert property (cmd && tx_byte == sccx_pkg::SC_PK285 |=>
        tx_sym.raw_en && tx_sym.raw == sccx_pkg::RAW_PK285) else $error("bad forced pos comma");
    a_rx_no_fill: assert property (rx_out_valid |->
        !(rx_out.sc && rx_out.byte_val[7:1] == 7'h10)) else $error("fill code decoded");
    a_rx_neg_wrong: assert property (rx_valid && rx_char == sccx_pkg::RAW_NK285 && rx_rd |=>
        rx_out.sc && rx_out.byte_val == sccx_pkg::SC_NK285) else $error("bad neg comma report");
    a_rx_pos_wrong: assert property (rx_valid && rx_char == sccx_pkg::RAW_PK285 && !rx_rd |=>
        rx_out.sc && rx_out.byte_val == sccx_pkg::SC_PK285) else $error("bad pos comma report");
    a_rx_unknown: assert property (rx_valid && no_hit && rx_char != sccx_pkg::RAW_NK285 &&
        rx_char != sccx_pkg::RAW_PK285 |=> rx_out.byte_val == sccx_pkg::SC_CRV) else $error("bad unknown report");
endmodule : sccx_codec_monitor
`default_nettype wire

// >>> dv/sccx_host.sv
`timescale 1ns/1ps
`default_nettype none
module sccx_host (
    input wire logic clk,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic special_char_select,
    output logic send_violation_symbol,
    output logic tx_rd
);
    // Quiet lane from time zero
    initial begin
        tx_valid = 1'b0;
        tx_byte = 8'h00;
        special_char_select = 1'b0;
        send_violation_symbol = 1'b0;
        tx_rd = 1'b0;
    end
    // One byte per byte clock; only defined codes are offered
    task put(input logic [7:0] b, input logic s, input logic v, input logic rd);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_byte <= b;
        special_char_select <= s;
        send_violation_symbol <= v;
        tx_rd <= rd;
    endtask : put
    // Stale byte inverted so a missed valid shows up
    task idle();
        @(posedge clk);
        tx_valid <= 1'b0;
        tx_byte <= ~tx_byte;
    endtask : idle
endmodule : sccx_host
`default_nettype wire

// >>> dv/special_char_codec_8b10b_bench.sv
`timescale 1ns/1ps
`default_nettype none
module special_char_codec_8b10b_bench;
    localparam logic [20:0] RM = 21'h1803FF;
    localparam logic [20:0] KM = 21'h1FFC00;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic tx_valid, special_char_select, send_violation_symbol, tx_rd, tx_sym_valid, rx_out_valid, rx_rd;
    logic [7:0] tx_byte;
    sccx_pkg::sccx_tx_sym_t tx_sym;
    sccx_pkg::sccx_rx_byte_t rx_out;
    logic rx_valid = 1'b0;
    logic [9:0] rx_char = 10'h000;
    logic rx_hn = 1'b0;
    logic rx_hp = 1'b0;
    logic rx_hk = 1'b0;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    // 200 MHz byte clock
    initial forever #2.5 clk = ~clk;
    sccx_codec i_dut (.clk, .resetn, .tx_valid, .tx_byte, .special_char_select, .send_violation_symbol, .tx_rd,
        .tx_sym_valid, .tx_sym, .rx_valid, .rx_char, .rx_tab_hit_neg(rx_hn), .rx_tab_hit_pos(rx_hp),
        .rx_tab_k(rx_hk), .rx_tab_byte(8'h5A), .rx_out_valid, .rx_out, .rx_rd);
    sccx_host i_host (.clk, .tx_valid, .tx_byte, .special_char_select, .send_violation_symbol, .tx_rd);
    ////////////////////////////////////////////////////////////////////////////
    task close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // Masked compare; unknowns under the mask never match
    task chk(input logic [20:0] got, input logic [20:0] exp, input logic [20:0] m);
        compares++;
        if ((got & m) !== (exp & m)) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask : chk
    function automatic logic [20:0] er(input logic [9:0] r);
        return {3'b110, 8'h00, r};
    endfunction : er
    function automatic logic [20:0] ek(input logic k, input logic [7:0] b);
        return {2'b10, k, b, 10'h000};
    endfunction : ek
    task tx1(input logic [7:0] b, input logic s, input logic v, input logic rd, input logic [20:0] e,
        input logic [20:0] m);
        i_host.put(b, s, v, rd);
        i_host.idle();
        #1 chk({tx_sym_valid, tx_sym}, e, m);
    endtask : tx1
    ////////////////////////////////////////////////////////////////////////////
    task t_codes();
        logic [9:0] crv;
        for (int r = 0; r < 2; r++) begin
            crv = r[0] ? sccx_pkg::RAW_CRV_P : sccx_pkg::RAW_CRV_N;
            tx1(sccx_pkg::SC_CRV, 1'b1, 1'b0, r[0], er(crv), RM);
            tx1(8'h3C, 1'b0, 1'b1, r[0], er(crv), RM);
            tx1(sccx_pkg::SC_RDV, 1'b1, 1'b0, r[0], er(r[0] ? 10'h08A : 10'h375), RM);
            tx1(sccx_pkg::SC_NK285, 1'b1, 1'b0, r[0], er(10'h0FA), RM);
            tx1(sccx_pkg::SC_PK285, 1'b1, 1'b0, r[0], er(10'h305), RM);
            tx1(sccx_pkg::SC_IDLE, 1'b1, 1'b0, r[0], er(10'h0FA), RM);
            tx1(sccx_pkg::SC_RRDY, 1'b1, 1'b0, r[0], er(10'h0FA), RM);
        end
        $display("codes done");
    endtask : t_codes
    task t_kcodes();
        logic [7:0] kt [4] = '{8'hF7, 8'hFB, 8'hFD, 8'hFE};
        for (int i = 0; i < 12; i++) begin
            tx1(i[7:0], 1'b1, 1'b0, 1'b0, ek(1'b1, (i < 8) ? {i[2:0], 5'h1C} : kt[i - 8]), KM);
        end
        tx1(8'h05, 1'b0, 1'b0, 1'b0, ek(1'b0, 8'h05), KM);
        $display("k codes done");
    endtask : t_kcodes
    // Eight bytes of fill, two whole sequences
    task t_fill(input logic [7:0] c, input logic [7:0] sec);
        int k;
        for (int i = 0; i < 9; i++) begin
            if (i < 8) begin
                i_host.put(c, 1'b1, 1'b0, i[0]);
            end else begin
                i_host.idle();
            end
            k = (i + 3) % 4;
            #1;
            if (i > 0) begin
                chk({tx_sym_valid, tx_sym}, k == 0 ? er(10'h0FA) : ek(1'b0, k == 1 ? 8'h95 : sec), k == 0 ? RM : KM);
            end
        end
        $display("fill done");
    endtask : t_fill
    // Fill cut short by a flavour switch and then by data
    task t_cut();
        i_host.put(sccx_pkg::SC_IDLE, 1'b1, 1'b0, 1'b0);
        i_host.put(sccx_pkg::SC_IDLE, 1'b1, 1'b0, 1'b0);
        #1 chk({tx_sym_valid, tx_sym}, er(10'h0FA), RM);
        i_host.put(sccx_pkg::SC_RRDY, 1'b1, 1'b0, 1'b0);
        #1 chk({tx_sym_valid, tx_sym}, ek(1'b0, 8'h95), KM);
        i_host.put(8'h33, 1'b0, 1'b0, 1'b0);
        #1 chk({tx_sym_valid, tx_sym}, er(10'h0FA), RM);
        i_host.idle();
        #1 chk({tx_sym_valid, tx_sym}, ek(1'b0, 8'h33), KM);
        $display("cut done");
    endtask : t_cut
    // Delimiter then a byte whose low bit is the wrong way round
    task t_eof();
        for (int r = 0; r < 2; r++) begin
            i_host.put(sccx_pkg::SC_EOF, 1'b1, 1'b0, r[0]);
            i_host.put({7'h2A, r[0]}, 1'b0, 1'b0, r[0]);
            #1 chk({tx_sym_valid, tx_sym}, ek(1'b1, 8'hBC), KM);
            i_host.idle();
            #1 chk({tx_sym_valid, tx_sym}, ek(1'b0, {7'h2A, ~r[0]}), KM);
        end
        $display("eof done");
    endtask : t_eof
    task rx1(input logic [9:0] c, input logic hn, input logic hp, input logic hk, input logic rd,
        input logic [8:0] e);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_char <= c;
        rx_hn <= hn;
        rx_hp <= hp;
        rx_hk <= hk;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
        #1 chk({10'h000, rx_rd, rx_out_valid, rx_out}, {10'h000, rd, 1'b1, e}, 21'h0007FF);
    endtask : rx1
    // Running disparity walks minus, plus, plus, minus, minus, plus
    task t_rx();
        rx1(10'h0FA, 1'b0, 1'b0, 1'b0, 1'b1, 9'h105);
        rx1(10'h0FA, 1'b0, 1'b0, 1'b0, 1'b1, 9'h1E1);
        rx1(10'h305, 1'b0, 1'b0, 1'b0, 1'b0, 9'h105);
        rx1(10'h305, 1'b0, 1'b0, 1'b0, 1'b0, 9'h1E2);
        rx1(10'h3FF, 1'b0, 1'b0, 1'b0, 1'b1, 9'h1E0);
        rx1(10'h01F, 1'b1, 1'b0, 1'b0, 1'b1, 9'h1E4);
        rx1(10'h01F, 1'b0, 1'b1, 1'b0, 1'b1, 9'h05A);
        rx1(10'h01F, 1'b0, 1'b1, 1'b1, 1'b1, 9'h15A);
        $display("rx done");
    endtask : t_rx
    // Reset mid-stream drops a pending delimiter and the tracked disparity
    task t_reset();
        i_host.put(sccx_pkg::SC_EOF, 1'b1, 1'b0, 1'b0);
        i_host.idle();
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1 chk({18'h00000, tx_sym_valid, rx_out_valid, rx_rd}, 21'h000000, 21'h000007);
        tx1(8'h55, 1'b0, 1'b0, 1'b1, ek(1'b0, 8'h55), KM);
        rx1(10'h0FA, 1'b0, 1'b0, 1'b0, 1'b1, 9'h105);
        $display("reset done");
    endtask : t_reset
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_codes();
        t_kcodes();
        t_fill(sccx_pkg::SC_IDLE, 8'hB5);
        t_fill(sccx_pkg::SC_RRDY, 8'h4A);
        t_cut();
        t_eof();
        t_rx();
        t_reset();
        close_out();
    end
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            close_out();
        end
    end
endmodule : special_char_codec_8b10b_bench
bind sccx_codec sccx_codec_monitor i_mon (.clk, .resetn, .tx_valid, .tx_byte, .special_char_select,
    .send_violation_symbol, .tx_rd, .tx_sym, .rx_valid, .rx_char, .rx_tab_hit_neg, .rx_tab_hit_pos,
    .rx_out_valid, .rx_out, .rx_rd);
`default_nettype wire
